// ---- crxb_pkg.sv ----
// constants and carrier types for the can receive buffer bookkeeping block
// assumes a 32-bit apb register bus and a single peripheral clock
package crxb_pkg;

   // buffer geometry
   localparam int NBUF = 32;
   localparam int BUF_IDX_W = 5;
   localparam int PTR_W = 6;
   localparam int HIT_W = 5;
   localparam int HALF_W = 16;
   localparam logic [4:0] BUF_LAST = 5'h1F;

   // register byte offsets
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_FIFO = 12'h000;
   localparam logic [11:0] OFS_FULL_LO = 12'h004;
   localparam logic [11:0] OFS_FULL_HI = 12'h008;
   localparam logic [11:0] OFS_FIFO_CFG = 12'h00C;
   localparam logic [11:0] OFS_INT_STAT = 12'h010;
   localparam logic [11:0] OFS_INT_MASK = 12'h014;
   localparam logic [11:0] OFS_STAT_BASE = 12'h080;
   localparam logic [11:0] STAT_SPAN = 12'h080;

   // field positions
   localparam int WBP_LSB = 8;
   localparam int NRP_LSB = 0;
   localparam int HIT_LSB = 8;
   localparam int CFG_START_LSB = 0;

   // interrupt events
   localparam int EV_STORED = 0;
   localparam int EV_OVERRUN = 1;
   localparam int EV_W = 2;

   // reset values
   localparam logic [4:0] FIFO_START_RST = 5'h00;
   localparam logic [4:0] PTR_RST = 5'h00;
   localparam logic [4:0] HIT_RST = 5'h00;
   localparam logic [1:0] EV_RST = 2'h0;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // a message stored by the protocol engine
   typedef struct packed
   {
      logic valid;
      logic [HIT_W-1:0] filter;
   } crxb_store_t;

   // register read answer
   typedef struct packed
   {
      logic err;
      logic [31:0] data;
   } crxb_rd_t;

endpackage

// ---- crxb_full_flags.sv ----
// one full flag per message buffer, set by hardware, cleared by software
// assumes set and clear vectors are synchronous to pclk
`timescale 1ns/1ns
module crxb_full_flags
   import crxb_pkg::*;
#(
   parameter int NBUF_P = NBUF
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // requests
   input wire logic [NBUF_P-1:0] set_vec,
   input wire logic [NBUF_P-1:0] clr_vec,
   // flags
   output logic [NBUF_P-1:0] full_ff
);

   if (NBUF_P < 2 || NBUF_P > NBUF)
   begin : g_bad_nbuf
      $error("crxb_full_flags: NBUF_P out of range");
   end

   for (genvar i = 0; i < NBUF_P; i++)
   begin : g_flag
      // a store in the clearing cycle keeps the flag set
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            full_ff[i] <= 1'b0;
         else if (set_vec[i])
            full_ff[i] <= 1'b1;
         else if (clr_vec[i])
            full_ff[i] <= 1'b0;
      end
   end

endmodule

// ---- crxb_wrap_ptr.sv ----
// buffer pointer that steps by one and wraps from the last buffer
// back to a programmable first buffer of the fifo area
`timescale 1ns/1ns
module crxb_wrap_ptr
   import crxb_pkg::*;
#(
   parameter int IDX_W = BUF_IDX_W
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic inc,
   input wire logic [IDX_W-1:0] first_idx,
   // pointer
   output logic [IDX_W-1:0] ptr_ff
);

   logic [IDX_W-1:0] nxt_ptr;

   if (IDX_W < 1 || IDX_W > BUF_IDX_W)
   begin : g_bad_width
      $error("crxb_wrap_ptr: IDX_W out of range");
   end

   always_comb
   begin
      nxt_ptr = ptr_ff;
      if (inc)
      begin
         if (ptr_ff == {IDX_W{1'b1}})
            nxt_ptr = first_idx;
         else
            nxt_ptr = ptr_ff + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ptr_ff <= PTR_RST[IDX_W-1:0];
      else
         ptr_ff <= nxt_ptr;
   end

endmodule

// ---- crxb_top.sv ----
// receive buffer bookkeeping: fifo pointers, full flags, filter hit codes
// assumes an apb master on pclk and a protocol engine that offers one
// stored message per store.valid cycle into buffer wr_buf_idx
`timescale 1ns/1ns

module crxb_top
   import crxb_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // protocol engine
   input wire crxb_store_t store,
   output logic [BUF_IDX_W-1:0] wr_buf_idx,
   output logic store_done,
   // interrupt
   output logic irq
);

   logic [NBUF-1:0] full_ff;
   logic [NBUF-1:0] set_vec;
   logic [NBUF-1:0] clr_vec;
   logic [BUF_IDX_W-1:0] wptr_ff;
   logic [BUF_IDX_W-1:0] rptr_ff;
   logic [BUF_IDX_W-1:0] fifo_start_ff;
   logic [HIT_W-1:0] hit_mem [NBUF];
   logic [EV_W-1:0] int_stat_ff;
   logic [EV_W-1:0] int_mask_ff;
   logic [EV_W-1:0] ev_set;
   logic [31:0] prdata_ff;
   logic err_ff;
   logic store_done_ff;
   logic store_ok;
   logic store_ovr;
   logic rd_inc;
   logic setup;
   logic acc;
   logic acc_wr;
   crxb_rd_t rd_ans;

   // true for a word address inside the per-buffer status window
   function automatic logic is_stat(input logic [ADDR_W-1:0] a);
      is_stat = (a >= OFS_STAT_BASE) && (a < OFS_STAT_BASE + STAT_SPAN)
         && (a[1:0] == 2'b00);
   endfunction

   // buffer number of a status window address
   function automatic logic [BUF_IDX_W-1:0] stat_idx(
      input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] ofs;
      ofs = a - OFS_STAT_BASE;
      stat_idx = ofs[BUF_IDX_W+1:2];
   endfunction

   // ---------------- apb phases ----------------
   assign setup = psel & ~penable;
   assign acc = psel & penable;
   assign acc_wr = acc & pwrite;

   // ---------------- store path ----------------
   // a store into a buffer still full is dropped and reported
   assign store_ok = store.valid & ~full_ff[wptr_ff];
   assign store_ovr = store.valid & full_ff[wptr_ff];

   always_comb
   begin
      set_vec = '0;
      if (store_ok)
         set_vec[wptr_ff] = 1'b1;
   end

   // writing a one clears, writing zero leaves the flag alone
   always_comb
   begin
      clr_vec = '0;
      if (acc_wr && paddr == OFS_FULL_LO)
         clr_vec[HALF_W-1:0] = pwdata[HALF_W-1:0];
      if (acc_wr && paddr == OFS_FULL_HI)
         clr_vec[NBUF-1:HALF_W] = pwdata[HALF_W-1:0];
   end

   crxb_full_flags #(
      .NBUF_P(NBUF)
   ) u_flags (
      .pclk(pclk),
      .presetn(presetn),
      .set_vec(set_vec),
      .clr_vec(clr_vec),
      .full_ff(full_ff)
   );

   // read pointer moves once software empties the buffer it names
   assign rd_inc = clr_vec[rptr_ff] & full_ff[rptr_ff] & ~set_vec[rptr_ff];

   crxb_wrap_ptr #(
      .IDX_W(BUF_IDX_W)
   ) u_wptr (
      .pclk(pclk),
      .presetn(presetn),
      .inc(store_ok),
      .first_idx(fifo_start_ff),
      .ptr_ff(wptr_ff)
   );

   crxb_wrap_ptr #(
      .IDX_W(BUF_IDX_W)
   ) u_rptr (
      .pclk(pclk),
      .presetn(presetn),
      .inc(rd_inc),
      .first_idx(fifo_start_ff),
      .ptr_ff(rptr_ff)
   );

   // filter hit codes; a hardware store beats a software write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < NBUF; i++)
            hit_mem[i] <= HIT_RST;
      end
      else if (store_ok)
         hit_mem[wptr_ff] <= store.filter;
      else if (acc_wr && is_stat(paddr))
         hit_mem[stat_idx(paddr)] <= pwdata[HIT_LSB +: HIT_W];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         store_done_ff <= 1'b0;
      else
         store_done_ff <= store_ok;
   end

   // ---------------- configuration ----------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fifo_start_ff <= FIFO_START_RST;
      else if (acc_wr && paddr == OFS_FIFO_CFG)
         fifo_start_ff <= pwdata[CFG_START_LSB +: BUF_IDX_W];
   end

   // ---------------- interrupts ----------------
   always_comb
   begin
      ev_set = EV_RST;
      ev_set[EV_STORED] = store_ok;
      ev_set[EV_OVERRUN] = store_ovr;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         int_stat_ff <= EV_RST;
      else if (acc_wr && paddr == OFS_INT_STAT)
         int_stat_ff <= ev_set | (int_stat_ff & ~pwdata[EV_W-1:0]);
      else
         int_stat_ff <= ev_set | int_stat_ff;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         int_mask_ff <= EV_RST;
      else if (acc_wr && paddr == OFS_INT_MASK)
         int_mask_ff <= pwdata[EV_W-1:0];
   end

   // ---------------- read decode ----------------
   always_comb
   begin
      rd_ans.err = 1'b0;
      rd_ans.data = WORD_ZERO;
      if (paddr == OFS_FIFO)
      begin
         rd_ans.data[WBP_LSB +: PTR_W] = {1'b0, wptr_ff};
         rd_ans.data[NRP_LSB +: PTR_W] = {1'b0, rptr_ff};
      end
      else if (paddr == OFS_FULL_LO)
         rd_ans.data[HALF_W-1:0] = full_ff[HALF_W-1:0];
      else if (paddr == OFS_FULL_HI)
         rd_ans.data[HALF_W-1:0] = full_ff[NBUF-1:HALF_W];
      else if (paddr == OFS_FIFO_CFG)
         rd_ans.data[CFG_START_LSB +: BUF_IDX_W] = fifo_start_ff;
      else if (paddr == OFS_INT_STAT)
         rd_ans.data[EV_W-1:0] = int_stat_ff;
      else if (paddr == OFS_INT_MASK)
         rd_ans.data[EV_W-1:0] = int_mask_ff;
      else if (is_stat(paddr))
         rd_ans.data[HIT_LSB +: HIT_W] = hit_mem[stat_idx(paddr)];
      else
         rd_ans.err = 1'b1;
   end

   // answer is prepared in the setup cycle so the access needs no wait
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff <= WORD_ZERO;
         err_ff <= 1'b0;
      end
      else if (setup)
      begin
         prdata_ff <= pwrite ? WORD_ZERO : rd_ans.data;
         err_ff <= rd_ans.err;
      end
   end

   assign prdata = prdata_ff;
   assign pready = 1'b1;
   assign pslverr = acc & err_ff;
   assign wr_buf_idx = wptr_ff;
   assign store_done = store_done_ff;
   assign irq = |(int_stat_ff & int_mask_ff);

   // ---------------- checks ----------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_ptr_read_layout: assert property (
      setup && !pwrite && paddr == OFS_FIFO |=>
         prdata[WBP_LSB +: PTR_W] == {1'b0, $past(wptr_ff)} &&
         prdata[NRP_LSB +: PTR_W] == {1'b0, $past(rptr_ff)})
      else $error("pointer register read wrong");

   a_store_sets_flag: assert property (
      store_ok |=> full_ff[$past(wptr_ff)] && store_done)
      else $error("stored buffer not marked full");

   a_full_hi_map: assert property (
      setup && !pwrite && paddr == OFS_FULL_HI |=>
         prdata[HALF_W-1:0] == $past(full_ff[NBUF-1:HALF_W]))
      else $error("upper full flags misplaced");

   a_hit_code_kept: assert property (
      store_ok |=> hit_mem[$past(wptr_ff)] == $past(store.filter))
      else $error("filter hit code not recorded");

   a_unused_bits_zero: assert property (
      acc && !pwrite && (paddr == OFS_FIFO || is_stat(paddr)) |->
         prdata[31:HALF_W] == 16'h0000 && prdata[7:6] == 2'b00 &&
         prdata[15:14] == 2'b00 &&
         (paddr == OFS_FIFO || (prdata[7:0] == 8'h00 &&
         prdata[15:13] == 3'b000)))
      else $error("unimplemented bits not zero");

   a_wptr_wraps: assert property (
      store_ok && wptr_ff == BUF_LAST |=> wptr_ff == $past(fifo_start_ff))
      else $error("write pointer did not wrap");

   a_rptr_steps: assert property (
      rd_inc && rptr_ff != BUF_LAST |=> rptr_ff == $past(rptr_ff) + 5'h01)
      else $error("read pointer did not step");

   a_full_lo_map: assert property (
      setup && !pwrite && paddr == OFS_FULL_LO |=>
         prdata[HALF_W-1:0] == $past(full_ff[HALF_W-1:0]) &&
         prdata[31:HALF_W] == 16'h0000)
      else $error("lower full flags misplaced");

   a_flag_rise_store: assert property (
      (full_ff & ~$past(full_ff) & ~$past(set_vec)) == {NBUF{1'b0}})
      else $error("full flag set without a store");

   a_flag_fall_clear: assert property (
      (~full_ff & $past(full_ff) & ~$past(clr_vec)) == {NBUF{1'b0}})
      else $error("full flag dropped without a clear");

   a_clear_lo_done: assert property (
      acc_wr && paddr == OFS_FULL_LO |=>
         (full_ff[HALF_W-1:0] & $past(pwdata[HALF_W-1:0]) &
         ~$past(set_vec[HALF_W-1:0])) == 16'h0000)
      else $error("lower full flags not cleared");

   a_clear_hi_done: assert property (
      acc_wr && paddr == OFS_FULL_HI |=>
         (full_ff[NBUF-1:HALF_W] & $past(pwdata[HALF_W-1:0]) &
         ~$past(set_vec[NBUF-1:HALF_W])) == 16'h0000)
      else $error("upper full flags not cleared");

   a_done_after_store: assert property (
      store_done |-> $past(store_ok))
      else $error("store_done without a store");

   a_wptr_steps: assert property (
      store_ok && wptr_ff != BUF_LAST |=>
         wptr_ff == $past(wptr_ff) + 5'h01)
      else $error("write pointer did not step");

   a_wptr_holds: assert property (
      store_ovr |=> wptr_ff == $past(wptr_ff) && !store_done)
      else $error("overrun moved the write pointer");

   a_rptr_wraps: assert property (
      rd_inc && rptr_ff == BUF_LAST |=> rptr_ff == $past(fifo_start_ff))
      else $error("read pointer did not wrap");

   a_rptr_holds: assert property (
      !rd_inc |=> rptr_ff == $past(rptr_ff))
      else $error("read pointer moved unasked");

   a_ptr_read_only: assert property (
      acc_wr && paddr == OFS_FIFO && !store_ok |=>
         wptr_ff == $past(wptr_ff) && rptr_ff == $past(rptr_ff))
      else $error("pointer register took a write");

   a_hit_kept_ovr: assert property (
      store_ovr && !(acc_wr && is_stat(paddr)) |=>
         hit_mem[$past(wptr_ff)] == $past(hit_mem[wptr_ff]))
      else $error("overrun changed a filter hit code");

   a_irq_on_store: assert property (
      store_ok && int_mask_ff[EV_STORED] &&
         !(acc_wr && paddr == OFS_INT_MASK) |=> irq)
      else $error("unmasked store event gave no interrupt");

   a_unmapped_read_zero: assert property (
      setup && !pwrite && paddr > OFS_INT_MASK && !is_stat(paddr) |=>
         prdata == WORD_ZERO && (!acc || pslverr))
      else $error("unmapped read not refused");

   c_ptr_wrap: cover property (store_ok && wptr_ff == BUF_LAST);
   c_overrun: cover property (store_ovr ##1 irq);
   c_read_step: cover property (rd_inc ##[1:8] rd_inc);
   c_start_wrap: cover property (
      store_ok && wptr_ff == BUF_LAST && fifo_start_ff != FIFO_START_RST);
   c_refused_read: cover property (acc && pslverr);

endmodule

// ---- crxb_engine_model.sv ----
// protocol engine stand-in: offers stored messages with a filter code
// assumes the bench calls burst from its clocked sequence
`timescale 1ns/1ns
module crxb_engine_model
   import crxb_pkg::*;
(
   // clock
   input wire logic pclk,
   // store request
   output crxb_store_t store
);
   initial
   begin
      store = '{valid: 1'b0, filter: 5'h00};
   end
   // back-to-back stores, filter codes counting up from f0
   task automatic burst(input int n, input logic [4:0] f0);
      logic [4:0] f;
      f = f0;
      for (int i = 0; i < n; i++)
      begin
         f = f0 + 5'(i);
         @(posedge pclk);
         store <= '{valid: 1'b1, filter: f};
      end
      @(posedge pclk);
      // idle filter shows no stale code
      store <= '{valid: 1'b0, filter: ~f};
   endtask
endmodule

// ---- crxb_top_test.sv ----
// self-checking bench for the receive buffer bookkeeping block
// assumes the engine model drives store and the bench is the apb master
`timescale 1ns/1ns
module crxb_top_test;
   import crxb_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic store_done, irq;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [BUF_IDX_W-1:0] wr_buf_idx;
   crxb_store_t store;
   int err_count, n_compared;
   crxb_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .store(store),
      .wr_buf_idx(wr_buf_idx), .store_done(store_done), .irq(irq));
   crxb_engine_model eng (.pclk(pclk), .store(store));
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic summarize;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   // one apb transfer; read data and error taken at the pready edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
         if (n > 20)
         begin
            err_count++;
            summarize();
         end
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [11:0] a,
      input logic [31:0] x);
      logic e;
      apb(1'b0, a, WORD_ZERO, rd, e);
      chk(nm, x, rd);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic e;
      apb(1'b1, a, d, rd, e);
   endtask
   task automatic t_reset;
      rchk("ptr", OFS_FIFO, 32'h0000_0000);
      rchk("full_lo", OFS_FULL_LO, 32'h0000_0000);
      rchk("full_hi", OFS_FULL_HI, 32'h0000_0000);
      $display("test reset done");
   endtask
   task automatic t_store;
      eng.burst(17, 5'h00);
      #1;
      chk("done", 32'(store_done), 32'h0000_0001);
      chk("wr_idx", 32'(wr_buf_idx), 32'h0000_0011);
      rchk("full_lo", OFS_FULL_LO, 32'h0000_FFFF);
      rchk("full_hi", OFS_FULL_HI, 32'h0000_0001);
      rchk("hit16", 12'h0C0, 32'h0000_1000);
      rchk("ptr", OFS_FIFO, 32'h0000_1100);
      $display("test store done");
   endtask
   task automatic t_clear;
      wr(OFS_FULL_HI, 32'h0000_FFFE);
      rchk("full_hi", OFS_FULL_HI, 32'h0000_0001);
      wr(OFS_FULL_LO, 32'h0000_0001);
      rchk("full_lo", OFS_FULL_LO, 32'h0000_FFFE);
      rchk("ptr", OFS_FIFO, 32'h0000_1101);
      $display("test clear done");
   endtask
   task automatic t_irq;
      logic e;
      wr(OFS_INT_MASK, 32'h0000_0001);
      #1;
      chk("irq_on", 32'(irq), 32'h0000_0001);
      wr(OFS_INT_STAT, 32'h0000_0001);
      #1;
      chk("irq_off", 32'(irq), 32'h0000_0000);
      apb(1'b0, 12'hFF0, WORD_ZERO, rd, e);
      chk("slverr", 32'(e), 32'h0000_0001);
      chk("unmapped_rd", WORD_ZERO, rd);
      $display("test irq done");
   endtask
   task automatic t_ovr;
      wr(OFS_INT_MASK, 32'h0000_0002);
      #1;
      chk("irq_masked", 32'(irq), 32'h0000_0000);
      eng.burst(1, 5'h0A);
      #1;
      chk("ovr_done", 32'(store_done), 32'h0000_0000);
      chk("ovr_idx", 32'(wr_buf_idx), 32'h0000_0001);
      chk("irq_ovr", 32'(irq), 32'h0000_0001);
      rchk("hit1", 12'h084, 32'h0000_0100);
      rchk("int_stat", OFS_INT_STAT, 32'h0000_0003);
      wr(OFS_FIFO, 32'h0000_3F3F);
      rchk("ptr", OFS_FIFO, 32'h0000_0101);
      $display("test overrun done");
   endtask
   task automatic t_start;
      logic [11:0] a;
      wr(OFS_FIFO_CFG, 32'h0000_0010);
      rchk("start", OFS_FIFO_CFG, 32'h0000_0010);
      wr(OFS_FULL_LO, 32'h0000_FFFF);
      wr(OFS_FULL_HI, 32'h0000_FFFF);
      rchk("ptr", OFS_FIFO, 32'h0000_0102);
      eng.burst(31, 5'h00);
      #1;
      chk("start_idx", 32'(wr_buf_idx), 32'h0000_0010);
      rchk("hit31", 12'h0FC, 32'h0000_1E00);
      rchk("full_lo", OFS_FULL_LO, 32'h0000_FFFE);
      rchk("full_hi", OFS_FULL_HI, 32'h0000_FFFF);
      for (int i = 2; i < NBUF; i++)
      begin
         a = (i < HALF_W) ? OFS_FULL_LO : OFS_FULL_HI;
         wr(a, 32'(1) << (i % HALF_W));
      end
      rchk("ptr", OFS_FIFO, 32'h0000_1010);
      rchk("full_lo", OFS_FULL_LO, 32'h0000_0002);
      rchk("full_hi", OFS_FULL_HI, 32'h0000_0000);
      $display("test start done");
   endtask
   task automatic t_wrap;
      eng.burst(15, 5'h11);
      #1;
      chk("wrap_idx", 32'(wr_buf_idx), 32'h0000_0000);
      eng.burst(1, 5'h1F);
      #1;
      chk("wr_idx1", 32'(wr_buf_idx), 32'h0000_0001);
      rchk("hit0", OFS_STAT_BASE, 32'h0000_1F00);
      rchk("ptr", OFS_FIFO, 32'h0000_0101);
      $display("test wrap done");
   endtask
   initial
   begin
      err_count = 0;
      n_compared = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = WORD_ZERO;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_store();
      t_clear();
      t_irq();
      t_wrap();
      t_ovr();
      t_start();
      summarize();
   end
endmodule
